// [core/tbc_timer16.v]
`timescale 1ns/1ps
`default_nettype none
`include "tbc_defs.vh"

module tbc_timer16 (
	input wire i_sys_clk,
	input wire i_rst_n,
	// byte-wide cpu access
	input wire [`TBC_ADDR_W-1:0] i_cpu_addr,
	input wire i_cpu_wr,
	input wire i_cpu_rd,
	input wire [7:0] i_cpu_wdata,
	output reg [7:0] o_cpu_rdata_q,
	// external tick pin
	input wire i_ext_tick_pin,
	// capture unit strobe, same clock
	input wire i_capture_strobe,
	// overflow flag clear, one-cycle pulse
	input wire i_ovf_clear,
	// state to the rest of the timer
	output reg [15:0] o_timer_count_q,
	output reg [15:0] o_compare_value_a_q,
	output reg [15:0] o_compare_value_b_q,
	output reg [15:0] o_capture_value_q,
	output reg [7:0] o_control_reg_a_q,
	output reg [7:0] o_control_reg_b_q,
	output reg o_timer_tick_q,
	output reg o_count_up_q,
	output reg o_top_q,
	output reg o_bottom_q,
	output reg o_counter_overflow_flag_q
);

	////////////////////////////////////////////////////////////////////////
	// internal state

	reg [7:0] high_latch_q;
	reg count_dir_down_q;
	reg [15:0] count_d;
	reg count_dir_down_d;
	reg [15:0] top_value;
	reg [`TBC_SEQ_W-1:0] seq_kind;
	reg capt_is_top;
	reg tick_sel;
	reg ovf_event;
	reg [7:0] rdata_d;

	wire [3:0] waveform_mode_field;
	wire [2:0] tick_source_select;
	wire div8;
	wire div64;
	wire div256;
	wire div1024;
	wire ext_rise;
	wire ext_fall;

	// field extraction from the two control registers
	assign waveform_mode_field = {o_control_reg_b_q[`TBC_CTRLB_WGM_HI],
		o_control_reg_a_q[`TBC_CTRLA_WGM_LO]};
	assign tick_source_select = o_control_reg_b_q[`TBC_CTRLB_CS];

	// cpu strobe decode
	wire wr_count_lo = i_cpu_wr && (i_cpu_addr == `TBC_A_COUNT_LO);
	wire wr_cmpa_lo = i_cpu_wr && (i_cpu_addr == `TBC_A_CMPA_LO);
	wire wr_cmpb_lo = i_cpu_wr && (i_cpu_addr == `TBC_A_CMPB_LO);
	wire wr_capt_lo = i_cpu_wr && (i_cpu_addr == `TBC_A_CAPT_LO);
	wire wr_any_hi = i_cpu_wr && ((i_cpu_addr == `TBC_A_COUNT_HI) ||
		(i_cpu_addr == `TBC_A_CMPA_HI) || (i_cpu_addr == `TBC_A_CMPB_HI) ||
		(i_cpu_addr == `TBC_A_CAPT_HI));
	wire wr_ctrl_a = i_cpu_wr && (i_cpu_addr == `TBC_A_CTRL_A);
	wire wr_ctrl_b = i_cpu_wr && (i_cpu_addr == `TBC_A_CTRL_B);
	wire rd_count_lo = i_cpu_rd && !i_cpu_wr && (i_cpu_addr == `TBC_A_COUNT_LO);
	wire rd_capt_lo = i_cpu_rd && !i_cpu_wr && (i_cpu_addr == `TBC_A_CAPT_LO);

	////////////////////////////////////////////////////////////////////////
	// tick sources

	tbc_prescaler u_prescaler (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.o_div8_q(div8),
		.o_div64_q(div64),
		.o_div256_q(div256),
		.o_div1024_q(div1024)
	);

	tbc_pin_sync u_ext_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_pin(i_ext_tick_pin),
		.o_rise_q(ext_rise),
		.o_fall_q(ext_fall)
	);

	// source select; zero gives no tick at all
	always @* begin
		case (tick_source_select)
			`TBC_CS_STOP: tick_sel = 1'b0;
			`TBC_CS_DIV1: tick_sel = 1'b1;
			`TBC_CS_DIV8: tick_sel = div8;
			`TBC_CS_DIV64: tick_sel = div64;
			`TBC_CS_DIV256: tick_sel = div256;
			`TBC_CS_DIV1024: tick_sel = div1024;
			`TBC_CS_EXT_FALL: tick_sel = ext_fall;
			`TBC_CS_EXT_RISE: tick_sel = ext_rise;
			default: tick_sel = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// mode decode: top value and sequence kind

	always @* begin
		top_value = `TBC_MAX;
		seq_kind = `TBC_SEQ_SINGLE;
		capt_is_top = 1'b0;
		case (waveform_mode_field)
			`TBC_WGM_NORMAL: begin
				top_value = `TBC_MAX;
			end
			`TBC_WGM_PC8: begin
				top_value = `TBC_TOP_8BIT;
				seq_kind = `TBC_SEQ_DUAL;
			end
			`TBC_WGM_PC9: begin
				top_value = `TBC_TOP_9BIT;
				seq_kind = `TBC_SEQ_DUAL;
			end
			`TBC_WGM_PC10: begin
				top_value = `TBC_TOP_10BIT;
				seq_kind = `TBC_SEQ_DUAL;
			end
			`TBC_WGM_CTC_CMPA: begin
				top_value = o_compare_value_a_q;
			end
			`TBC_WGM_FAST8: begin
				top_value = `TBC_TOP_8BIT;
				seq_kind = `TBC_SEQ_FAST;
			end
			`TBC_WGM_FAST9: begin
				top_value = `TBC_TOP_9BIT;
				seq_kind = `TBC_SEQ_FAST;
			end
			`TBC_WGM_FAST10: begin
				top_value = `TBC_TOP_10BIT;
				seq_kind = `TBC_SEQ_FAST;
			end
			`TBC_WGM_PFC_CAPT, `TBC_WGM_PC_CAPT: begin
				top_value = o_capture_value_q;
				seq_kind = `TBC_SEQ_DUAL;
				capt_is_top = 1'b1;
			end
			`TBC_WGM_PFC_CMPA, `TBC_WGM_PC_CMPA: begin
				top_value = o_compare_value_a_q;
				seq_kind = `TBC_SEQ_DUAL;
			end
			`TBC_WGM_CTC_CAPT: begin
				top_value = o_capture_value_q;
				capt_is_top = 1'b1;
			end
			`TBC_WGM_FAST_CAPT: begin
				top_value = o_capture_value_q;
				seq_kind = `TBC_SEQ_FAST;
				capt_is_top = 1'b1;
			end
			`TBC_WGM_FAST_CMPA: begin
				top_value = o_compare_value_a_q;
				seq_kind = `TBC_SEQ_FAST;
			end
			default: begin
				top_value = `TBC_MAX; // reserved code runs as normal
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next count, direction and overflow event

	always @* begin
		count_d = o_timer_count_q;
		count_dir_down_d = count_dir_down_q;
		ovf_event = 1'b0;
		if (wr_count_lo) begin
			// cpu write wins; the tick in this cycle is dropped
			count_d = {high_latch_q, i_cpu_wdata};
		end else if (tick_sel) begin
			case (seq_kind)
				`TBC_SEQ_SINGLE: begin
					// past a lowered top the count runs on to max and wraps
					if (o_timer_count_q == top_value)
						count_d = `TBC_BOTTOM;
					else
						count_d = o_timer_count_q + `TBC_ONE;
					ovf_event = (o_timer_count_q == `TBC_MAX);
				end
				`TBC_SEQ_FAST: begin
					if (o_timer_count_q == top_value)
						count_d = `TBC_BOTTOM;
					else
						count_d = o_timer_count_q + `TBC_ONE;
					ovf_event = (o_timer_count_q == top_value);
				end
				`TBC_SEQ_DUAL: begin
					if (!count_dir_down_q) begin
						if (o_timer_count_q >= top_value) begin
							count_dir_down_d = 1'b1;
							count_d = o_timer_count_q - `TBC_ONE;
						end else begin
							count_d = o_timer_count_q + `TBC_ONE;
						end
					end else begin
						if (o_timer_count_q == `TBC_BOTTOM) begin
							count_dir_down_d = 1'b0;
							count_d = o_timer_count_q + `TBC_ONE;
						end else begin
							count_d = o_timer_count_q - `TBC_ONE;
						end
					end
					ovf_event = (o_timer_count_q == `TBC_BOTTOM);
				end
				default: begin
					count_d = o_timer_count_q;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// counter, flag and indications

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_timer_count_q <= `TBC_RST_WORD;
			count_dir_down_q <= 1'b0;
			o_counter_overflow_flag_q <= 1'b0;
			o_timer_tick_q <= 1'b0;
			o_count_up_q <= 1'b1;
			o_top_q <= 1'b0;
			o_bottom_q <= 1'b1;
		end else begin
			o_timer_count_q <= count_d;
			// single-slope modes always count up
			count_dir_down_q <= count_dir_down_d & (seq_kind == `TBC_SEQ_DUAL);
			// a set in the same cycle as the clear wins
			if (ovf_event)
				o_counter_overflow_flag_q <= 1'b1;
			else if (i_ovf_clear)
				o_counter_overflow_flag_q <= 1'b0;
			o_timer_tick_q <= tick_sel;
			o_count_up_q <= !(count_dir_down_d & (seq_kind == `TBC_SEQ_DUAL));
			o_top_q <= (count_d == top_value);
			o_bottom_q <= (count_d == `TBC_BOTTOM);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shared high-byte latch, control and 16-bit data registers

	// one latch for all four words; kept until the next update
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			high_latch_q <= `TBC_RST_BYTE;
		end else if (wr_any_hi) begin
			high_latch_q <= i_cpu_wdata;
		end else if (rd_count_lo) begin
			high_latch_q <= o_timer_count_q[15:8];
		end else if (rd_capt_lo) begin
			high_latch_q <= o_capture_value_q[15:8];
		end
	end

	// control bytes, compare values and capture value
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_control_reg_a_q <= `TBC_RST_BYTE;
			o_control_reg_b_q <= `TBC_RST_BYTE;
			o_compare_value_a_q <= `TBC_RST_WORD;
			o_compare_value_b_q <= `TBC_RST_WORD;
			o_capture_value_q <= `TBC_RST_WORD;
		end else begin
			if (wr_ctrl_a)
				o_control_reg_a_q <= i_cpu_wdata;
			if (wr_ctrl_b)
				o_control_reg_b_q <= i_cpu_wdata;
			if (wr_cmpa_lo)
				o_compare_value_a_q <= {high_latch_q, i_cpu_wdata};
			if (wr_cmpb_lo)
				o_compare_value_b_q <= {high_latch_q, i_cpu_wdata};
			// capture is writable only while it defines top; the strobe loads it only while it does not
			if (wr_capt_lo && capt_is_top)
				o_capture_value_q <= {high_latch_q, i_cpu_wdata};
			else if (i_capture_strobe && !capt_is_top)
				o_capture_value_q <= o_timer_count_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data

	always @* begin
		case (i_cpu_addr)
			`TBC_A_COUNT_LO: rdata_d = o_timer_count_q[7:0];
			`TBC_A_COUNT_HI: rdata_d = high_latch_q;
			`TBC_A_CMPA_LO: rdata_d = o_compare_value_a_q[7:0];
			`TBC_A_CMPA_HI: rdata_d = o_compare_value_a_q[15:8];
			`TBC_A_CMPB_LO: rdata_d = o_compare_value_b_q[7:0];
			`TBC_A_CMPB_HI: rdata_d = o_compare_value_b_q[15:8];
			`TBC_A_CAPT_LO: rdata_d = o_capture_value_q[7:0];
			`TBC_A_CAPT_HI: rdata_d = high_latch_q;
			`TBC_A_CTRL_A: rdata_d = o_control_reg_a_q;
			`TBC_A_CTRL_B: rdata_d = o_control_reg_b_q;
			default: rdata_d = `TBC_RST_BYTE;
		endcase
	end

	// read data is registered; it holds until the next read strobe
	always @(posedge i_sys_clk) begin
		if (!i_rst_n)
			o_cpu_rdata_q <= `TBC_RST_BYTE;
		else if (i_cpu_rd && !i_cpu_wr)
			o_cpu_rdata_q <= rdata_d;
	end

endmodule
`default_nettype wire

// [core/tbc_defs.vh]
`ifndef TBC_DEFS_VH
`define TBC_DEFS_VH

// byte addresses on the cpu port
`define TBC_ADDR_W 4
`define TBC_A_COUNT_LO 4'h0
`define TBC_A_COUNT_HI 4'h1
`define TBC_A_CMPA_LO 4'h2
`define TBC_A_CMPA_HI 4'h3
`define TBC_A_CMPB_LO 4'h4
`define TBC_A_CMPB_HI 4'h5
`define TBC_A_CAPT_LO 4'h6
`define TBC_A_CAPT_HI 4'h7
`define TBC_A_CTRL_A 4'h8
`define TBC_A_CTRL_B 4'h9

// field layout of the control registers
`define TBC_CTRLA_WGM_LO 1:0
`define TBC_CTRLB_WGM_HI 4:3
`define TBC_CTRLB_CS 2:0

// reset values
`define TBC_RST_BYTE 8'h00
`define TBC_RST_WORD 16'h0000

// fixed count values
`define TBC_BOTTOM 16'h0000
`define TBC_MAX 16'hFFFF
`define TBC_TOP_8BIT 16'h00FF
`define TBC_TOP_9BIT 16'h01FF
`define TBC_TOP_10BIT 16'h03FF
`define TBC_ONE 16'h0001

// tick source select codes
`define TBC_CS_STOP 3'h0
`define TBC_CS_DIV1 3'h1
`define TBC_CS_DIV8 3'h2
`define TBC_CS_DIV64 3'h3
`define TBC_CS_DIV256 3'h4
`define TBC_CS_DIV1024 3'h5
`define TBC_CS_EXT_FALL 3'h6
`define TBC_CS_EXT_RISE 3'h7

// prescaler divider masks (low bits all ones marks the tap)
`define TBC_PRE_W 10
`define TBC_PRE_M8 10'h007
`define TBC_PRE_M64 10'h03F
`define TBC_PRE_M256 10'h0FF
`define TBC_PRE_M1024 10'h3FF
`define TBC_PRE_ONE 10'h001

// waveform mode codes
`define TBC_WGM_NORMAL 4'h0
`define TBC_WGM_PC8 4'h1
`define TBC_WGM_PC9 4'h2
`define TBC_WGM_PC10 4'h3
`define TBC_WGM_CTC_CMPA 4'h4
`define TBC_WGM_FAST8 4'h5
`define TBC_WGM_FAST9 4'h6
`define TBC_WGM_FAST10 4'h7
`define TBC_WGM_PFC_CAPT 4'h8
`define TBC_WGM_PFC_CMPA 4'h9
`define TBC_WGM_PC_CAPT 4'hA
`define TBC_WGM_PC_CMPA 4'hB
`define TBC_WGM_CTC_CAPT 4'hC
`define TBC_WGM_RSVD 4'hD
`define TBC_WGM_FAST_CAPT 4'hE
`define TBC_WGM_FAST_CMPA 4'hF

// count sequence kinds, one-hot
`define TBC_SEQ_W 3
`define TBC_SEQ_SINGLE 3'b001
`define TBC_SEQ_FAST 3'b010
`define TBC_SEQ_DUAL 3'b100

`endif

// [core/tbc_pin_sync.v]
`timescale 1ns/1ps
`default_nettype none
`include "tbc_defs.vh"

module tbc_pin_sync (
	input wire i_sys_clk,
	input wire i_rst_n,
	input wire i_pin,
	output reg o_rise_q,
	output reg o_fall_q
);

	reg s1_q;
	reg s2_q;
	reg s3_q;
	reg level_q;

	// three-stage synchroniser; a level counts once stages two and three agree
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_q <= 1'b0;
			o_rise_q <= 1'b0;
			o_fall_q <= 1'b0;
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
			o_rise_q <= (s2_q == s3_q) && s3_q && !level_q;
			o_fall_q <= (s2_q == s3_q) && !s3_q && level_q;
		end
	end

endmodule
`default_nettype wire

// [core/tbc_prescaler.v]
`timescale 1ns/1ps
`default_nettype none
`include "tbc_defs.vh"

module tbc_prescaler (
	input wire i_sys_clk,
	input wire i_rst_n,
	output reg o_div8_q,
	output reg o_div64_q,
	output reg o_div256_q,
	output reg o_div1024_q
);

	reg [`TBC_PRE_W-1:0] pre_q;

	// free-running divider; shared taps, so phase is not tied to a select change
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			pre_q <= {`TBC_PRE_W{1'b0}};
			o_div8_q <= 1'b0;
			o_div64_q <= 1'b0;
			o_div256_q <= 1'b0;
			o_div1024_q <= 1'b0;
		end else begin
			pre_q <= pre_q + `TBC_PRE_ONE;
			o_div8_q <= (pre_q & `TBC_PRE_M8) == `TBC_PRE_M8;
			o_div64_q <= (pre_q & `TBC_PRE_M64) == `TBC_PRE_M64;
			o_div256_q <= (pre_q & `TBC_PRE_M256) == `TBC_PRE_M256;
			o_div1024_q <= (pre_q & `TBC_PRE_M1024) == `TBC_PRE_M1024;
		end
	end

endmodule
`default_nettype wire

// [tb/tbc_timer16_properties.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tbc_defs.vh"

module tbc_timer16_properties (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [`TBC_ADDR_W-1:0] i_cpu_addr,
	input wire logic i_cpu_wr,
	input wire logic i_cpu_rd,
	input wire logic [7:0] i_cpu_wdata,
	input wire logic [7:0] o_cpu_rdata_q,
	input wire logic [15:0] o_timer_count_q,
	input wire logic [15:0] o_compare_value_a_q,
	input wire logic [15:0] o_compare_value_b_q,
	input wire logic [7:0] o_control_reg_a_q,
	input wire logic [7:0] o_control_reg_b_q,
	input wire logic o_top_q,
	input wire logic o_bottom_q,
	input wire logic o_timer_tick_q,
	input wire logic o_counter_overflow_flag_q
);
	logic [3:0] mode;
	logic [2:0] sel;
	logic rd_ok;
	// mode bits are split over two control bytes; a write beats a read
	assign mode = {o_control_reg_b_q[`TBC_CTRLB_WGM_HI], o_control_reg_a_q[`TBC_CTRLA_WGM_LO]};
	assign sel = o_control_reg_b_q[`TBC_CTRLB_CS];
	assign rd_ok = i_cpu_rd && !i_cpu_wr;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////////
	a_low_write_load:
	assert property ((i_cpu_wr && i_cpu_addr == `TBC_A_COUNT_HI) ##1
		(i_cpu_wr && i_cpu_addr == `TBC_A_COUNT_LO)
		|=> o_timer_count_q == {$past(i_cpu_wdata, 2), $past(i_cpu_wdata)})
		else $error("count not loaded as one word");
	a_latch_kept:
	assert property ((i_cpu_wr && i_cpu_addr == `TBC_A_COUNT_HI) ##1
		(i_cpu_wr && i_cpu_addr == `TBC_A_CMPA_LO) ##1 (i_cpu_wr && i_cpu_addr == `TBC_A_CMPB_LO)
		|=> o_compare_value_b_q == {$past(i_cpu_wdata, 3), $past(i_cpu_wdata)})
		else $error("shared high byte lost");
	a_stop_holds:
	assert property (sel == `TBC_CS_STOP && !i_cpu_wr |=> $stable(o_timer_count_q))
		else $error("count moved while stopped");
	a_tick_stopped:
	assert property (sel == `TBC_CS_STOP |=> !o_timer_tick_q)
		else $error("tick while stopped");
	a_count_step:
	assert property (sel == `TBC_CS_DIV1 && $past(sel) == `TBC_CS_DIV1
		&& mode == `TBC_WGM_NORMAL && !i_cpu_wr |=> o_timer_count_q == $past(o_timer_count_q) + 16'h0001)
		else $error("count did not step by one");
	a_ovf_normal:
	assert property ($past(o_timer_count_q) == `TBC_MAX && o_timer_count_q == `TBC_BOTTOM
		&& $past(mode) == `TBC_WGM_NORMAL && !$past(i_cpu_wr) |-> o_counter_overflow_flag_q)
		else $error("overflow flag not set on wrap");
	a_bottom_level:
	assert property (o_bottom_q == (o_timer_count_q == `TBC_BOTTOM))
		else $error("bottom does not track count");
	a_top_normal:
	assert property (mode == `TBC_WGM_NORMAL && $past(mode) == `TBC_WGM_NORMAL
		|-> o_top_q == (o_timer_count_q == `TBC_MAX))
		else $error("top wrong in normal mode");
	a_low_read:
	assert property (rd_ok && i_cpu_addr == `TBC_A_COUNT_LO |=> o_cpu_rdata_q == $past(o_timer_count_q[7:0]))
		else $error("count low read wrong");
	a_latch_read:
	assert property ((rd_ok && i_cpu_addr == `TBC_A_COUNT_LO) ##1 (rd_ok && i_cpu_addr == `TBC_A_COUNT_HI)
		|=> o_cpu_rdata_q == $past(o_timer_count_q[15:8], 2))
		else $error("count high read not from latch");
	a_cmp_direct:
	assert property (rd_ok && i_cpu_addr == `TBC_A_CMPA_HI |=> o_cpu_rdata_q == $past(o_compare_value_a_q[15:8]))
		else $error("compare high read not direct");
	a_unmapped_zero:
	assert property (rd_ok && i_cpu_addr > `TBC_A_CTRL_B |=> o_cpu_rdata_q == 8'h00)
		else $error("unmapped read not zero");
endmodule

bind tbc_timer16 tbc_timer16_properties u_props (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
	.i_cpu_addr(i_cpu_addr), .i_cpu_wr(i_cpu_wr), .i_cpu_rd(i_cpu_rd), .i_cpu_wdata(i_cpu_wdata),
	.o_cpu_rdata_q(o_cpu_rdata_q), .o_timer_count_q(o_timer_count_q),
	.o_compare_value_a_q(o_compare_value_a_q), .o_compare_value_b_q(o_compare_value_b_q),
	.o_control_reg_a_q(o_control_reg_a_q), .o_control_reg_b_q(o_control_reg_b_q),
	.o_top_q(o_top_q), .o_bottom_q(o_bottom_q), .o_timer_tick_q(o_timer_tick_q),
	.o_counter_overflow_flag_q(o_counter_overflow_flag_q));
`default_nettype wire

// [tb/tbc_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none

module tbc_cpu_model (
	input wire logic i_sys_clk,
	input wire logic [7:0] i_cpu_rdata,
	output logic [3:0] o_cpu_addr,
	output logic o_cpu_wr,
	output logic o_cpu_rd,
	output logic [7:0] o_cpu_wdata
);
	// bus idle at time zero
	initial begin
		o_cpu_addr = 4'h0;
		o_cpu_wr = 1'b0;
		o_cpu_rd = 1'b0;
		o_cpu_wdata = 8'h00;
	end
	////////////////////////////////////////////////////////////////
	// strobes stay up so calls run back to back; idle drops them
	task automatic wr8(input logic [3:0] a, input logic [7:0] d);
		@(negedge i_sys_clk);
		o_cpu_addr = a;
		o_cpu_wdata = d;
		o_cpu_rd = 1'b0;
		o_cpu_wr = 1'b1;
	endtask
	// data stays invalid off writes, so it is scrambled
	task automatic rd8(input logic [3:0] a, output logic [7:0] d);
		@(negedge i_sys_clk);
		o_cpu_addr = a;
		o_cpu_wdata = ~o_cpu_wdata;
		o_cpu_wr = 1'b0;
		o_cpu_rd = 1'b1;
		@(posedge i_sys_clk);
		#1;
		d = i_cpu_rdata;
	endtask
	task automatic idle();
		@(negedge i_sys_clk);
		o_cpu_wr = 1'b0;
		o_cpu_rd = 1'b0;
		o_cpu_wdata = ~o_cpu_wdata;
	endtask
	// two bytes with nothing between them keeps the latch ours
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		wr8(a + 4'h1, v[15:8]);
		wr8(a, v[7:0]);
	endtask
	task automatic rd16(input logic [3:0] a, output logic [15:0] v);
		logic [7:0] lo;
		logic [7:0] hi;
		rd8(a, lo);
		rd8(a + 4'h1, hi);
		v = {hi, lo};
	endtask
endmodule
`default_nettype wire

// [tb/timer16_counter_byte_access_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tbc_defs.vh"

module timer16_counter_byte_access_test;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic pin = 1'b0;
	logic cap = 1'b0;
	logic clr = 1'b0;
	wire [3:0] addr;
	wire wr;
	wire rd;
	wire [7:0] wdata;
	wire [7:0] rdata;
	wire [15:0] count;
	wire [15:0] cmpa;
	wire [15:0] cmpb;
	wire [15:0] capt;
	wire [7:0] ctla;
	wire [7:0] ctlb;
	wire up;
	wire tick;
	wire top;
	wire ovf;
	wire bot;
	logic [15:0] rv;
	// the dual slope entry comes first so a single-slope one clears its direction
	logic [3:0] modes [6] = '{4'h1, 4'h5, 4'h6, 4'h7, 4'hF, 4'h4};
	logic [15:0] tops [6] = '{16'h00FF, 16'h00FF, 16'h01FF, 16'h03FF, 16'h1234, 16'h1234};
	// eight prescaled ticks fit exactly in eight divider periods
	logic [2:0] sels [4] = '{`TBC_CS_DIV8, `TBC_CS_DIV64, `TBC_CS_DIV256, `TBC_CS_DIV1024};
	int divs [4] = '{8, 64, 256, 1024};
	int n_errors = 0;
	int total_checks = 0;
	always #5 i_sys_clk = ~i_sys_clk;
	////////////////////////////////////////////////////////////////
	tbc_timer16 u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cpu_addr(addr),
		.i_cpu_wr(wr), .i_cpu_rd(rd), .i_cpu_wdata(wdata), .o_cpu_rdata_q(rdata),
		.i_ext_tick_pin(pin), .i_capture_strobe(cap), .i_ovf_clear(clr),
		.o_timer_count_q(count), .o_compare_value_a_q(cmpa), .o_compare_value_b_q(cmpb),
		.o_capture_value_q(capt), .o_control_reg_a_q(ctla), .o_control_reg_b_q(ctlb),
		.o_timer_tick_q(tick), .o_count_up_q(up), .o_top_q(top), .o_bottom_q(bot),
		.o_counter_overflow_flag_q(ovf));
	tbc_cpu_model u_cpu (.i_sys_clk(i_sys_clk), .i_cpu_rdata(rdata), .o_cpu_addr(addr),
		.o_cpu_wr(wr), .o_cpu_rd(rd), .o_cpu_wdata(wdata));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// both control bytes, then bus idle
	task automatic set_mode(input logic [3:0] m, input logic [2:0] cs);
		u_cpu.wr8(`TBC_A_CTRL_A, {6'h00, m[1:0]});
		u_cpu.wr8(`TBC_A_CTRL_B, {3'h0, m[3:2], cs});
		u_cpu.idle();
	endtask
	// bounded wait, a missed event shows up in the next compare
	task automatic wait_hi(input int which);
		for (int i = 0; i < 20; i++) begin
			if ((which == 0 ? top : ovf) === 1'b1) break;
			@(negedge i_sys_clk);
		end
	endtask
	// about eleven thousand cycles, most of them in the prescaler test
	initial begin
		#300000;
		n_errors++;
		$display("[ERR] watchdog expected done seen hang");
		complete_run();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(negedge i_sys_clk);
		i_rst_n = 1'b1;
		repeat (3) @(negedge i_sys_clk);
		chk("count", 16'h0000, count);
		chk("ctrl b", 16'h0000, 16'(ctlb));
		chk("flag", 16'h0000, 16'(ovf));
		chk("bottom", 16'h0001, 16'(bot));
		u_cpu.rd8(`TBC_A_COUNT_HI, rv[7:0]);
		chk("latch", 16'h0000, 16'(rv[7:0]));
		u_cpu.rd8(4'hF, rv[7:0]);
		chk("unmapped", 16'h0000, 16'(rv[7:0]));
		$display("test reset done");
		u_cpu.wr16(`TBC_A_COUNT_LO, 16'h01FF);
		u_cpu.idle();
		chk("count", 16'h01FF, count);
		u_cpu.rd16(`TBC_A_COUNT_LO, rv);
		chk("count read", 16'h01FF, rv);
		// one high byte serves three low writes; capture refused here
		u_cpu.wr8(`TBC_A_COUNT_HI, 8'h12);
		u_cpu.wr8(`TBC_A_CMPA_LO, 8'h34);
		u_cpu.wr8(`TBC_A_CMPB_LO, 8'h56);
		u_cpu.wr8(`TBC_A_CAPT_LO, 8'h78);
		u_cpu.idle();
		chk("cmp a", 16'h1234, cmpa);
		chk("cmp b", 16'h1256, cmpb);
		chk("capture", 16'h0000, capt);
		chk("count", 16'h01FF, count);
		u_cpu.rd8(`TBC_A_COUNT_LO, rv[7:0]);
		u_cpu.rd8(`TBC_A_CMPA_HI, rv[7:0]);
		chk("cmp a high", 16'h0012, 16'(rv[7:0]));
		u_cpu.rd8(`TBC_A_COUNT_HI, rv[7:0]);
		chk("latch kept", 16'h0001, 16'(rv[7:0]));
		$display("test byte access done");
		u_cpu.wr16(`TBC_A_COUNT_LO, 16'hFFFC);
		set_mode(`TBC_WGM_NORMAL, `TBC_CS_DIV1);
		wait_hi(1);
		chk("flag", 16'h0001, 16'(ovf));
		chk("wrap", 16'h0000, count);
		u_cpu.wr16(`TBC_A_COUNT_LO, 16'h0500);
		u_cpu.idle();
		chk("write wins", 16'h0500, count);
		chk("tick run", 16'h0001, 16'(tick));
		set_mode(`TBC_WGM_NORMAL, `TBC_CS_STOP);
		rv = count;
		repeat (5) @(negedge i_sys_clk);
		chk("stopped", rv, count);
		chk("tick stop", 16'h0000, 16'(tick));
		clr = 1'b1;
		@(negedge i_sys_clk);
		clr = 1'b0;
		chk("flag clear", 16'h0000, 16'(ovf));
		$display("test count done");
		for (int k = 0; k < 6; k++) begin
			u_cpu.wr16(`TBC_A_COUNT_LO, tops[k] - 16'h0003);
			set_mode(modes[k], `TBC_CS_DIV1);
			wait_hi(0);
			chk("top", tops[k], count);
			chk("ctrl a", 16'({6'h00, modes[k][1:0]}), 16'(ctla));
			set_mode(modes[k], `TBC_CS_STOP);
		end
		// capture defines top here, so its low write is taken
		set_mode(`TBC_WGM_CTC_CAPT, `TBC_CS_STOP);
		u_cpu.wr16(`TBC_A_CAPT_LO, 16'h0010);
		u_cpu.wr16(`TBC_A_COUNT_LO, 16'h000D);
		set_mode(`TBC_WGM_CTC_CAPT, `TBC_CS_DIV1);
		wait_hi(0);
		chk("capture", 16'h0010, capt);
		chk("capture top", 16'h0010, count);
		@(negedge i_sys_clk);
		chk("clear at top", 16'h0000, count);
		set_mode(`TBC_WGM_CTC_CAPT, `TBC_CS_STOP);
		// dual slope turns round at its top
		u_cpu.wr16(`TBC_A_COUNT_LO, 16'h03FD);
		set_mode(`TBC_WGM_PC10, `TBC_CS_DIV1);
		wait_hi(0);
		@(negedge i_sys_clk);
		chk("down", 16'h03FE, count);
		chk("dir", 16'h0000, 16'(up));
		// free-running divider: any window of eight periods holds eight ticks
		for (int j = 0; j < 4; j++) begin
			set_mode(`TBC_WGM_NORMAL, `TBC_CS_STOP);
			u_cpu.wr16(`TBC_A_COUNT_LO, 16'h0000);
			set_mode(`TBC_WGM_NORMAL, sels[j]);
			repeat (8 * divs[j]) @(negedge i_sys_clk);
			chk("prescaled", 16'h0008, count);
		end
		$display("test modes done");
		set_mode(`TBC_WGM_NORMAL, `TBC_CS_EXT_RISE);
		u_cpu.wr16(`TBC_A_COUNT_LO, 16'h0000);
		u_cpu.idle();
		pin = 1'b1;
		repeat (8) @(negedge i_sys_clk);
		chk("pin rise", 16'h0001, count);
		set_mode(`TBC_WGM_NORMAL, `TBC_CS_EXT_FALL);
		pin = 1'b0;
		repeat (8) @(negedge i_sys_clk);
		chk("pin fall", 16'h0002, count);
		cap = 1'b1;
		@(negedge i_sys_clk);
		cap = 1'b0;
		chk("capture", 16'h0002, capt);
		$display("test tick source done");
		complete_run();
	end
endmodule
`default_nettype wire
